// ---- mcf_pkg.sv ----
// Constants, register map and types for the microcycle timing and flag control block
package mcf_pkg;

    // Master clock timing
    localparam int MCLK_PERIOD_NS  = 175;
    localparam int SYS_CLK_NS      = 20;
    localparam int MCLK_HALF_CYC   = (MCLK_PERIOD_NS / 2) / SYS_CLK_NS;
    localparam int MCLK_CNT_W      = 3;
    localparam logic [MCLK_CNT_W-1:0] MCLK_HALF_LAST = MCLK_CNT_W'(MCLK_HALF_CYC - 1);

    // Ring counter
    localparam int              RING_W     = 8;
    localparam logic [RING_W-1:0] RING_CLEAR = 8'h00;
    localparam logic [RING_W-1:0] RING_FIRST = 8'h01;
    localparam int T1_POS = 0;
    localparam int T2_POS = 1;
    localparam int T3_POS = 2;
    localparam int T4_POS = 3;
    localparam int T5_POS = 4;
    localparam int T6_POS = 5;
    localparam int T7_POS = 6;
    localparam int T8_POS = 7;

    // Instruction layout and flag opcodes
    localparam logic [4:0] SET_FLAG_OPC   = 5'h05;
    localparam logic [4:0] PULSE_FLAG_OPC = 5'h07;
    localparam int         OPC_MSB        = 7;
    localparam int         OPC_LSB        = 3;
    localparam int         FC_MSB         = 2;

    // Flag select codes
    localparam logic [2:0] FC_MICRO0  = 3'h0;
    localparam logic [2:0] FC_USER1   = 3'h1;
    localparam logic [2:0] FC_USER4   = 3'h4;
    localparam logic [2:0] FC_MICRO5  = 3'h5;
    localparam logic [2:0] FC_SELECT  = 3'h6;
    localparam logic [2:0] FC_INT_EN  = 3'h7;

    // Data-in pull-up level when strobe is inactive
    localparam logic [3:0] DIN_PULLUP = 4'hf;
    localparam logic [3:0] CMD_IDLE   = 4'h0;

    // APB register map (byte addresses)
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] CMD_OFS    = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] INSTR_OFS  = 8'h0c;

    // Control register fields
    localparam int CTRL_RUN_BIT  = 0;
    localparam logic CTRL_RUN_RST = 1'b1;

    // Status register fields
    localparam int STAT_RING_LSB = 0;
    localparam int STAT_FLAG_LSB = 8;
    localparam int STAT_JFA_LSB  = 16;

    // Command fields for the four odd intervals, in true (uncomplemented) form
    typedef struct packed {
        logic [3:0] t7Dest;
        logic [3:0] t5AluCtl;
        logic [3:0] t3BSel;
        logic [3:0] t1ASel;
    } mcf_cmd_t;

    localparam mcf_cmd_t CMD_RST = 16'h0000;

endpackage : mcf_pkg

// ---- mcf_timing_flag_ctl.sv ----
// Microcycle ring timing, command multiplexer, instruction capture and control flags
// Functional notes
// - Set opcode 00101, pulse opcode 00111, fc low.
// - Set instruction drives selected flag set.
// - Pulse: set at T2, reset at T6.
// - Codes 1-4 user, 6 select, 7 interrupt enable.
// - Control flags separate from slice status flags.
// - Symmetrical master clock, also driven out.
// - Timebase gated by init and memory hold.
// - Eight one-hot intervals, one period each.
// - Init clears ring; pulses then advance it.
// - T1 follows T8 with no gap.
// - Derived T3T4, clocked T5, T8-to-T4 pulses.
// - Phase clocks come from odd intervals only.
// - Command bits complemented, zero in even intervals.
// - T1 low bits select A-bus register.
// - T1 top bit is stack enable.
// - T3 B-bus select plus A complement.
// - T5 carries ALU operation and controls.
// - T7 destination plus multiplexer source select.
// - Instruction byte captured during T7.
// - Strobe gates only low data bits at T7.
// - Jump/flag address driven from T1.
// - Flag enable low at T2 set, T6 reset.
`timescale 1ns/1ns

module mcf_timing_flag_ctl
    import mcf_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        clkEn,
    // Card pins
    input  wire logic        initN,
    input  wire logic        timebaseHoldN,
    input  wire logic        memAccess,
    input  wire logic [7:0]  dataOut,
    input  wire logic        dataInStrobeN,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Timing outputs
    output logic             timebaseOut,
    output logic [7:0]       intervals,
    output logic [3:0]       phaseClocks,
    output logic             pulseT3T4,
    output logic             gatedT5Pulse,
    output logic             pulseT8ToT4,
    // Command bus and sequencer outputs
    output logic [3:0]       commandN,
    output logic [3:0]       jumpFlagAddr,
    output logic             flagEnableN,
    output logic [3:0]       userFlags,
    output logic             selectFlag,
    output logic             interruptEnableFlag
);

    // Decodes a flag instruction: returns 2'b01 set, 2'b10 pulse, else zero
    function automatic logic [1:0] flagOpKind(input logic [7:0] instr);
        logic [4:0] opc;
        opc = instr[OPC_MSB:OPC_LSB];
        flagOpKind = {opc == PULSE_FLAG_OPC, opc == SET_FLAG_OPC};
    endfunction : flagOpKind

    // Maps a flag select code onto the one-hot flag vector
    function automatic logic [7:0] flagDecode(input logic [2:0] code);
        flagDecode = 8'h01 << code;
    endfunction : flagDecode

    logic [1:0]   initSync_r;
    logic [1:0]   holdSync_r;
    logic [1:0]   strobeSync_r;
    logic [7:0]   doutMeta_r;
    logic [7:0]   doutSync_r;
    logic         ctrlRun_r;
    mcf_cmd_t     cmdFields_r;
    logic [MCLK_CNT_W-1:0] mclkCnt_r;
    logic         mclk_r;
    logic         mclkNxt;
    logic         mclkRise;
    logic         gateOpen;
    logic         advance;
    logic [7:0]   ring_r;
    logic [7:0]   ringNxt;
    logic [7:0]   instr_r;
    logic [7:0]   flagState_r;
    logic [3:0]   seqDataLow;
    logic [1:0]   curOp;
    logic         apbAccess;

    // Two-stage synchronisers for card pins other than memAccess
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            initSync_r   <= 2'b00;
            holdSync_r   <= 2'b11;
            strobeSync_r <= 2'b11;
            doutMeta_r   <= 8'h00;
            doutSync_r   <= 8'h00;
        end else if (clkEn) begin
            initSync_r   <= {initSync_r[0], initN};
            holdSync_r   <= {holdSync_r[0], timebaseHoldN};
            strobeSync_r <= {strobeSync_r[0], dataInStrobeN};
            doutMeta_r   <= dataOut;
            doutSync_r   <= doutMeta_r;
        end
    end

    // APB slave, one wait state: pready is high in the second access cycle
    assign apbAccess = psel && penable && pready;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (clkEn) begin
            pready  <= psel && penable && !pready;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && penable && !pready) begin
                unique case (paddr)
                    CTRL_OFS:   prdata <= pwrite ? 32'h0 : {31'h0, ctrlRun_r};
                    CMD_OFS:    prdata <= pwrite ? 32'h0 : {16'h0, cmdFields_r};
                    STATUS_OFS: prdata <= pwrite ? 32'h0 :
                                    {12'h0, jumpFlagAddr, flagState_r, ring_r};
                    INSTR_OFS:  prdata <= pwrite ? 32'h0 : {24'h0, instr_r};
                    default:    pslverr <= 1'b1;
                endcase
            end
        end
    end

    // Software-owned run enable and command fields
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrlRun_r   <= CTRL_RUN_RST;
            cmdFields_r <= CMD_RST;
        end else if (clkEn && apbAccess && pwrite) begin
            if (paddr == CTRL_OFS)
                ctrlRun_r <= pwdata[CTRL_RUN_BIT];
            if (paddr == CMD_OFS)
                cmdFields_r <= mcf_cmd_t'(pwdata[15:0]);
        end
    end

    // Symmetrical master clock from a half-period divider; it runs free
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mclkCnt_r <= '0;
            mclk_r    <= 1'b0;
        end else if (clkEn) begin
            mclkCnt_r <= (mclkCnt_r == MCLK_HALF_LAST) ? '0 : mclkCnt_r + 1'b1;
            mclk_r    <= mclkNxt;
        end
    end

    assign mclkNxt  = (mclkCnt_r == MCLK_HALF_LAST) ? !mclk_r : mclk_r;
    assign mclkRise = (mclkCnt_r == MCLK_HALF_LAST) && !mclk_r;

    // Gating stops the ring while init is low or hold is low in a memory cycle
    assign gateOpen = initSync_r[1] && !(!holdSync_r[1] && memAccess) && ctrlRun_r;
    assign advance  = clkEn && mclkRise && gateOpen;

    always_comb begin
        ringNxt = ring_r;
        if (!initSync_r[1])
            ringNxt = RING_CLEAR;
        else if (advance)
            ringNxt = (ring_r == RING_CLEAR) ? RING_FIRST
                                             : {ring_r[6:0], ring_r[7]};
    end

    // Ring only moves on advance or an init clear, so a hold freezes it
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            ring_r <= RING_CLEAR;
        else if (clkEn)
            ring_r <= ringNxt;
    end

    // Registered timing outputs follow the next ring value and the next master clock value
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            timebaseOut  <= 1'b0;
            intervals    <= RING_CLEAR;
            phaseClocks  <= 4'h0;
            pulseT3T4    <= 1'b0;
            gatedT5Pulse <= 1'b0;
            pulseT8ToT4  <= 1'b0;
        end else if (clkEn) begin
            timebaseOut  <= mclkNxt;
            intervals    <= ringNxt;
            phaseClocks  <= {ringNxt[T7_POS], ringNxt[T5_POS],
                             ringNxt[T3_POS], ringNxt[T1_POS]};
            pulseT3T4    <= ringNxt[T3_POS] || ringNxt[T4_POS];
            gatedT5Pulse <= mclkNxt && ringNxt[T5_POS];
            pulseT8ToT4  <= ringNxt[T8_POS] || ringNxt[T1_POS] || ringNxt[T2_POS]
                         || ringNxt[T3_POS] || ringNxt[T4_POS];
        end
    end

    // Complemented command bits per odd interval, zero in even ones
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            commandN <= CMD_IDLE;
        else if (clkEn) begin
            unique case (1'b1)
                ringNxt[T1_POS]: commandN <= ~cmdFields_r.t1ASel;
                ringNxt[T3_POS]: commandN <= ~cmdFields_r.t3BSel;
                ringNxt[T5_POS]: commandN <= ~cmdFields_r.t5AluCtl;
                ringNxt[T7_POS]: commandN <= ~cmdFields_r.t7Dest;
                default:         commandN <= CMD_IDLE;
            endcase
        end
    end

    // Strobe gates only the low nibble; pull-ups read ones otherwise
    assign seqDataLow = !strobeSync_r[1] ? doutSync_r[3:0] : DIN_PULLUP;

    // Capture on the edge that ends T7
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            instr_r <= 8'h00;
        else if (advance && ring_r[T7_POS])
            instr_r <= {doutSync_r[7:4], seqDataLow};
    end

    assign curOp = flagOpKind(instr_r);

    // Jump/flag address presented from T1 and held for the microcycle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            jumpFlagAddr <= 4'h0;
        else if (advance && ringNxt[T1_POS])
            jumpFlagAddr <= {1'b0, instr_r[FC_MSB:0]};
    end

    // Flag enable low through T2 for set, through T6 for pulse reset
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            flagEnableN <= 1'b1;
        else if (clkEn)
            flagEnableN <= !((ringNxt[T2_POS] && curOp != 2'b00)
                          || (ringNxt[T6_POS] && curOp[1]));
    end

    // Control flags live here only, apart from the slice status flags
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            flagState_r <= 8'h00;
        else if (clkEn) begin
            if (!initSync_r[1])
                flagState_r <= 8'h00;
            else if (advance && ringNxt[T2_POS] && curOp != 2'b00)
                flagState_r <= flagState_r | flagDecode(jumpFlagAddr[2:0]);
            else if (advance && ringNxt[T6_POS] && curOp[1])
                flagState_r <= flagState_r & ~flagDecode(jumpFlagAddr[2:0]);
        end
    end

    // Codes 0 and 5 belong to the microprogram and have no pin here
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            userFlags           <= 4'h0;
            selectFlag          <= 1'b0;
            interruptEnableFlag <= 1'b0;
        end else if (clkEn) begin
            userFlags           <= flagState_r[FC_USER4:FC_USER1];
            selectFlag          <= flagState_r[FC_SELECT];
            interruptEnableFlag <= flagState_r[FC_INT_EN];
        end
    end

    a_ring_onehot: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ring_r != RING_CLEAR |-> $onehot(ring_r))
        else $error("ring counter not one-hot");

    a_ring_wrap: assert property (@(posedge sys_clk) disable iff (!reset_n)
        advance && ring_r[T8_POS] && initSync_r[1] |=> ring_r == RING_FIRST)
        else $error("T1 did not follow T8");

    a_init_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clkEn && !initSync_r[1] |=> ring_r == RING_CLEAR && flagState_r == 8'h00)
        else $error("init did not clear ring and flags");

    a_cmd_even_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !(intervals[T1_POS] || intervals[T3_POS] || intervals[T5_POS]
          || intervals[T7_POS]) |-> commandN == CMD_IDLE)
        else $error("command bits not zero in even interval");

    a_hold_freeze: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clkEn && initSync_r[1] && !holdSync_r[1] && memAccess |=> $stable(ring_r))
        else $error("ring moved during hold");

    a_flag_enable_time: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !flagEnableN |-> intervals[T2_POS] || intervals[T6_POS])
        else $error("flag enable outside T2 or T6");

    a_t34_pulse: assert property (@(posedge sys_clk) disable iff (!reset_n)
        pulseT3T4 == (intervals[T3_POS] || intervals[T4_POS]))
        else $error("T3T4 pulse mismatch");

    a_pulse_reset: assert property (@(posedge sys_clk) disable iff (!reset_n)
        advance && ringNxt[T6_POS] && curOp == 2'b10 && initSync_r[1]
        |=> !flagState_r[jumpFlagAddr[2:0]])
        else $error("pulsed flag not reset at T6");

    a_phase_odd: assert property (@(posedge sys_clk) disable iff (!reset_n)
        phaseClocks != 4'h0 |-> !(intervals[T2_POS] || intervals[T4_POS]
                                  || intervals[T6_POS] || intervals[T8_POS]))
        else $error("phase clock active in even interval");

endmodule : mcf_timing_flag_ctl

// ---- mcf_slice_model.sv ----
// Register and ALU slice stand-in that decodes the complemented command bus
`timescale 1ns/1ns
module mcf_slice_model
    import mcf_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic [7:0] intervals,
    input  wire logic [3:0] commandN,
    output mcf_cmd_t        seenCmd,
    output logic            evenBad
);
    initial evenBad = 1'b0;
    // Slices sample on every falling sys_clk edge, once the sequencer outputs have settled
    always @(negedge sys_clk) begin
        if (intervals[T1_POS]) seenCmd.t1ASel <= ~commandN;
        if (intervals[T3_POS]) seenCmd.t3BSel <= ~commandN;
        if (intervals[T5_POS]) seenCmd.t5AluCtl <= ~commandN;
        if (intervals[T7_POS]) seenCmd.t7Dest <= ~commandN;
        if ((intervals & 8'haa) != 8'h00 && commandN !== CMD_IDLE) evenBad <= 1'b1;
    end
endmodule : mcf_slice_model

// ---- tb_microcycle_timing_flag_control.sv ----
// Self-checking bench for the microcycle timing and flag control block
`timescale 1ns/1ns
module tb_microcycle_timing_flag_control
    import mcf_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        initN = 1'b0;
    logic        timebaseHoldN = 1'b1;
    logic        memAccess = 1'b0;
    logic [7:0]  dataOut = 8'h00;
    logic        dataInStrobeN = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, er, timebaseOut, pulseT3T4, gatedT5Pulse, pulseT8ToT4;
    logic [7:0]  intervals, e;
    logic [3:0]  phaseClocks, commandN, jumpFlagAddr, userFlags, c4, cf;
    logic        flagEnableN, selectFlag, interruptEnableFlag, evenBad;
    mcf_cmd_t    seenCmd, cmd;
    int          fails = 0;
    int          num_checks = 0;
    int          n, hi;

    always #10 sys_clk = ~sys_clk;

    mcf_timing_flag_ctl uut (.sys_clk(sys_clk), .reset_n(reset_n), .clkEn(1'b1),
        .initN(initN), .timebaseHoldN(timebaseHoldN), .memAccess(memAccess),
        .dataOut(dataOut), .dataInStrobeN(dataInStrobeN), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timebaseOut(timebaseOut), .intervals(intervals),
        .phaseClocks(phaseClocks), .pulseT3T4(pulseT3T4), .gatedT5Pulse(gatedT5Pulse),
        .pulseT8ToT4(pulseT8ToT4), .commandN(commandN), .jumpFlagAddr(jumpFlagAddr),
        .flagEnableN(flagEnableN), .userFlags(userFlags), .selectFlag(selectFlag),
        .interruptEnableFlag(interruptEnableFlag));

    mcf_slice_model slice (.sys_clk(sys_clk), .intervals(intervals), .commandN(commandN),
        .seenCmd(seenCmd), .evenBad(evenBad));

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        num_checks++;
        if (got !== ex) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", nm, ex, got);
        end
    endtask : chk

    task test_done;
        $display("checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done

    task automatic tmo;
        chk("wait bound", 0, 1);
        test_done();
    endtask : tmo

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Flops update after this process resumes, so these reads see the sampled values
        @(posedge sys_clk);
        while (pready !== 1'b1) begin
            k++;
            if (k > 20) tmo();
            @(posedge sys_clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic waitIv(input int k);
        int m;
        m = 0;
        @(negedge sys_clk);
        while (intervals !== 8'(1 << k)) begin
            m++;
            if (m > 200) tmo();
            @(negedge sys_clk);
        end
    endtask : waitIv

    function automatic logic flagPin(input int fc);
        logic [7:0] p;
        p = {interruptEnableFlag, selectFlag, 1'b0, userFlags, 1'b0};
        return p[fc];
    endfunction : flagPin

    // Instruction is fetched in one microcycle and executes in the next
    task automatic run(input logic [7:0] ins, input logic sn, input int fc, input logic pulse);
        waitIv(0);
        @(posedge sys_clk);
        dataOut <= ins;
        dataInStrobeN <= sn;
        waitIv(7);
        @(posedge sys_clk);
        dataOut <= 8'h00;
        dataInStrobeN <= 1'b1;
        waitIv(0);
        chk("jumpFlagAddr", fc, jumpFlagAddr);
        waitIv(1);
        @(negedge sys_clk);
        chk("flagEnableN T2", 0, flagEnableN);
        chk("flag pin T2", fc % 5 != 0, flagPin(fc));
        waitIv(2);
        chk("flagEnableN T3", 1, flagEnableN);
        waitIv(5);
        chk("flagEnableN T6", !pulse, flagEnableN);
        waitIv(6);
        chk("flag pin T7", fc % 5 != 0 && !pulse, flagPin(fc));
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("flag state", !pulse, rd[STAT_FLAG_LSB + fc]);
    endtask : run

    initial begin
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        chk("flagEnableN reset", 1, flagEnableN);
        apb(1'b0, CTRL_OFS, 32'h0);
        chk("ctrl reset", 32'h1, rd);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped error", 1, er);
        chk("intervals in init", 0, intervals);
        @(posedge sys_clk);
        initN <= 1'b1;
        n = 0;
        while (intervals === 8'h00 && n < 100) begin
            n++;
            @(negedge sys_clk);
        end
        chk("first interval", RING_FIRST, intervals);
        for (int w = 0; w < 2; w++) begin
            cmd = w ? 16'h3870 : 16'h9c5a;
            apb(1'b1, CMD_OFS, cmd);
            apb(1'b0, CMD_OFS, 32'h0);
            chk("command readback", cmd, rd[15:0]);
            waitIv(7);
            waitIv(0);
            for (int k = 0; k < 9; k++) begin
                e = 8'(1 << (k % 8));
                cf = (k % 2) ? CMD_IDLE : ~cmd[4 * ((k % 8) / 2) +: 4];
                chk("intervals", e, intervals);
                chk("phaseClocks", {e[6], e[4], e[2], e[0]}, phaseClocks);
                chk("pulseT3T4", e[2] | e[3], pulseT3T4);
                chk("pulseT8ToT4", e[7] | (|e[3:0]), pulseT8ToT4);
                chk("commandN", cf, commandN);
                n = 0;
                hi = 0;
                while (intervals === e && n < 20) begin
                    chk("gatedT5Pulse", timebaseOut & e[4], gatedT5Pulse);
                    n++;
                    hi += timebaseOut;
                    @(negedge sys_clk);
                end
                chk("interval length", 8, n);
                chk("timebase high", 4, hi);
            end
            chk("slice view", cmd, seenCmd);
        end
        chk("even command bits", 0, evenBad);
        // Strobe high forces the low bits to the pull-up, turning code 0 into code 7
        run(8'h28, 1'b1, 7, 1'b0);
        for (int fc = 0; fc < 8; fc++) begin
            run({PULSE_FLAG_OPC, 3'(fc)}, 1'b0, fc, 1'b1);
            run({SET_FLAG_OPC, 3'(fc)}, 1'b0, fc, 1'b0);
        end
        chk("flags held", 6'h3f, {interruptEnableFlag, selectFlag, userFlags});
        waitIv(3);
        @(posedge sys_clk);
        memAccess <= 1'b1;
        timebaseHoldN <= 1'b0;
        repeat (12) @(negedge sys_clk);
        e = intervals;
        c4 = commandN;
        repeat (30) @(negedge sys_clk);
        chk("held intervals", e, intervals);
        chk("held commandN", c4, commandN);
        @(posedge sys_clk);
        memAccess <= 1'b0;
        repeat (12) @(negedge sys_clk);
        chk("hold outside memory cycle", 1, intervals !== e);
        @(posedge sys_clk);
        timebaseHoldN <= 1'b1;
        apb(1'b1, CTRL_OFS, 32'h0);
        // The ring may still step on the edge that lands the write
        @(negedge sys_clk);
        e = intervals;
        repeat (30) @(negedge sys_clk);
        chk("stopped ring", e, intervals);
        apb(1'b1, CTRL_OFS, 32'h1);
        @(posedge sys_clk);
        initN <= 1'b0;
        repeat (20) @(negedge sys_clk);
        chk("init clears ring", 0, intervals);
        chk("init clears flags", 0, {interruptEnableFlag, selectFlag, userFlags});
        @(posedge sys_clk);
        initN <= 1'b1;
        n = 0;
        while (intervals === 8'h00 && n < 100) begin
            n++;
            @(negedge sys_clk);
        end
        chk("restart interval", RING_FIRST, intervals);
        test_done();
    end
endmodule : tb_microcycle_timing_flag_control
